// *** src/dig_input_capture.v ***
// input capture block: bypass, delay, sdr, ddr and gearbox capture
`include "dig_defs.vh"

module dig_input_capture #(
    parameter EDGE_SIDE = 1,
    parameter DLY_TAPS  = `DIG_DLY_TAPS
) (
    input  wire        sys_clk,
    input  wire        resetn,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        pad_input,
    input  wire        strobe_read_clock,
    input  wire        edge_clock,
    input  wire        sync_clock_polarity,
    input  wire        sync_transfer_latch,
    input  wire [3:0]  dynamic_delay_sel,
    output reg         comb_input_bypass,
    output reg         clock_input_bypass,
    output reg         sdr_data,
    output wire [3:0]  cap_data,
    output wire        cap_valid,
    input  wire        cap_ready,
    output reg         gearbox_out_pos_first,
    output reg         gearbox_out_neg_first,
    output reg         gearbox_out_pos_second,
    output reg         gearbox_out_neg_second
);

    // ****************************************
    // declarations
    // ****************************************
    reg  [11:0]         ctrl_reg;
    reg                 drop_reg;
    reg  [3:0]          last_reg;
    reg  [DLY_TAPS-1:0] dly_reg;
    reg                 pos_reg;
    reg                 neg_reg;
    reg  [1:0]          syn_reg;
    reg                 syn_vld_reg;
    reg  [1:0]          ecl_first_reg;
    reg  [1:0]          ecl_second_reg;
    reg                 ecl_slot_reg;
    reg                 ecl_full_reg;
    reg  [3:0]          word_reg;
    reg                 word_vld_reg;
    wire [8:0]          raw_in;
    wire [8:0]          s_q;
    wire [8:0]          s_rise;
    wire [8:0]          s_fall;
    wire                pad_s;
    wire                strb_r;
    wire                strb_f;
    wire                edge_clock_r;
    wire                edge_clock_f;
    wire                pol_s;
    wire                lat_s;
    wire [3:0]          dsel_s;
    wire [1:0]          mode;
    wire                mem_mode;
    wire                mode_err;
    wire                cap_r;
    wire                cap_f;
    wire                hand_off;
    wire [3:0]          tap;
    wire                data_d;
    wire                buf_ready;
    wire                req;

    // ****************************************
    // pin synchronisers
    // ****************************************
    assign raw_in = {dynamic_delay_sel, sync_transfer_latch, sync_clock_polarity,
                     edge_clock, strobe_read_clock, pad_input};

    dig_sync #(
        .W (9)
    ) u_sync (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .d       (raw_in),
        .q       (s_q),
        .rise    (s_rise),
        .fall    (s_fall)
    );

    assign pad_s  = s_q[0];
    assign strb_r = s_rise[1];
    assign strb_f = s_fall[1];
    assign edge_clock_r = s_rise[2];
    assign edge_clock_f = s_fall[2];
    assign pol_s  = s_q[3];
    assign lat_s  = s_q[4];
    assign dsel_s = s_q[8:5];

    // ****************************************
    // mode decode
    // ****************************************
    assign mode     = ctrl_reg[`DIG_CTRL_MODE_MSB:`DIG_CTRL_MODE_LSB];
    assign mem_mode = ctrl_reg[`DIG_CTRL_MEM_BIT];
    assign mode_err = (mode == `DIG_MODE_GEAR && EDGE_SIDE == 0) || (mode == 2'h3);
    assign cap_r    = mem_mode ? strb_r : edge_clock_r;
    assign cap_f    = mem_mode ? strb_f : edge_clock_f;
    assign hand_off = pol_s ? cap_r : cap_f;

    // ****************************************
    // input delay
    // ****************************************
    // fixed or dynamic tap
    assign tap    = ctrl_reg[`DIG_CTRL_DYN_BIT] ? dsel_s
                  : ctrl_reg[`DIG_CTRL_FIX_MSB:`DIG_CTRL_FIX_LSB];
    assign data_d = ctrl_reg[`DIG_CTRL_DEN_BIT] ? dly_reg[tap] : pad_s;

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dly_reg <= {DLY_TAPS{1'b0}};
        end else begin
            dly_reg <= {dly_reg[DLY_TAPS-2:0], pad_s};
        end
    end

    // ****************************************
    // bypass and sdr
    // ****************************************
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            comb_input_bypass  <= 1'b0;
            clock_input_bypass <= 1'b0;
            sdr_data           <= 1'b0;
        end else begin
            comb_input_bypass  <= pad_s;
            clock_input_bypass <= pad_s;
            if (mode == `DIG_MODE_SDR) begin
                sdr_data <= data_d;
            end
        end
    end

    // ****************************************
    // ddr capture and sync registers
    // ****************************************
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pos_reg     <= 1'b0;
            neg_reg     <= 1'b0;
            syn_reg     <= 2'h0;
            syn_vld_reg <= 1'b0;
        end else begin
            if (cap_r) begin
                pos_reg <= data_d;
            end
            if (cap_f) begin
                neg_reg <= data_d;
            end
            syn_vld_reg <= 1'b0;
            if (hand_off && !mode_err && mode != `DIG_MODE_SDR) begin
                // newest sample taken straight in, the other from its register
                syn_reg     <= pol_s ? {data_d, neg_reg} : {pos_reg, data_d};
                syn_vld_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // edge clock transfer and gearbox
    // ****************************************
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ecl_first_reg  <= 2'h0;
            ecl_second_reg <= 2'h0;
            ecl_slot_reg   <= 1'b0;
            ecl_full_reg   <= 1'b0;
            word_reg       <= 4'h0;
            word_vld_reg   <= 1'b0;
        end else begin
            word_vld_reg <= 1'b0;
            if (mode == `DIG_MODE_DDR && syn_vld_reg) begin
                word_reg     <= {2'h0, syn_reg};
                word_vld_reg <= 1'b1;
            end else if (mode == `DIG_MODE_GEAR && !mode_err) begin
                if (syn_vld_reg && !ecl_full_reg) begin
                    if (!ecl_slot_reg) begin
                        ecl_first_reg <= syn_reg;
                    end else begin
                        ecl_second_reg <= syn_reg;
                        ecl_full_reg   <= 1'b1;
                    end
                    ecl_slot_reg <= ~ecl_slot_reg;
                end
                if (lat_s && ecl_full_reg) begin
                    word_reg     <= {ecl_second_reg, ecl_first_reg};
                    word_vld_reg <= 1'b1;
                    ecl_full_reg <= 1'b0;
                end
            end else begin
                ecl_slot_reg <= 1'b0;
                ecl_full_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // gearbox outputs
    // ****************************************
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gearbox_out_pos_first  <= 1'b0;
            gearbox_out_neg_first  <= 1'b0;
            gearbox_out_pos_second <= 1'b0;
            gearbox_out_neg_second <= 1'b0;
        end else if (word_vld_reg && mode == `DIG_MODE_GEAR) begin
            gearbox_out_pos_first  <= word_reg[1];
            gearbox_out_neg_first  <= word_reg[0];
            gearbox_out_pos_second <= word_reg[3];
            gearbox_out_neg_second <= word_reg[2];
        end
    end

    // ****************************************
    // output buffer
    // ****************************************
    // a full buffer cannot stall the pad, so a refused word sets the sticky drop flag
    dig_buf2 #(
        .W (`DIG_WORD_W)
    ) u_buf (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .in_data   (word_reg),
        .in_valid  (word_vld_reg),
        .in_ready  (buf_ready),
        .out_data  (cap_data),
        .out_valid (cap_valid),
        .out_ready (cap_ready)
    );

    // ****************************************
    // avalon slave
    // ****************************************
    assign req = avs_read | avs_write;

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if (req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            if (avs_address == `DIG_CTRL_OFS) begin
                avs_readdata <= {20'h00000, ctrl_reg};
            end else if (avs_address == `DIG_STAT_OFS) begin
                avs_readdata <= {24'h000000, last_reg, 1'b0, cap_valid,
                                 mode_err, drop_reg};
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // ****************************************
    // control and status registers
    // ****************************************
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= `DIG_CTRL_RST;
            drop_reg <= 1'b0;
            last_reg <= 4'h0;
        end else begin
            if (avs_write && !avs_waitrequest && avs_address == `DIG_CTRL_OFS) begin
                // spare bits never stored, so they read back as zero
                ctrl_reg <= avs_writedata[11:0] & `DIG_CTRL_WMASK;
            end
            // set wins over write-one-to-clear
            if (word_vld_reg && !buf_ready) begin
                drop_reg <= 1'b1;
            end else if (avs_write && !avs_waitrequest
                         && avs_address == `DIG_STAT_OFS
                         && avs_writedata[`DIG_STAT_DROP_BIT]) begin
                drop_reg <= 1'b0;
            end
            if (word_vld_reg) begin
                last_reg <= word_reg;
            end
        end
    end

endmodule // dig_input_capture

// *** include/dig_defs.vh ***
// constants of the ddr input capture and gearbox block
`ifndef DIG_DEFS_VH
`define DIG_DEFS_VH

// ****************************************
// register byte offsets
// ****************************************
`define DIG_CTRL_OFS      4'h0
`define DIG_STAT_OFS      4'h4

// ****************************************
// control fields and reset
// ****************************************
`define DIG_CTRL_MODE_LSB 0
`define DIG_CTRL_MODE_MSB 1
`define DIG_CTRL_MEM_BIT  2
`define DIG_CTRL_DEN_BIT  3
`define DIG_CTRL_DYN_BIT  4
`define DIG_CTRL_FIX_LSB  8
`define DIG_CTRL_FIX_MSB  11
`define DIG_CTRL_RST      12'h000
`define DIG_CTRL_WMASK    12'hf1f

// ****************************************
// status fields
// ****************************************
`define DIG_STAT_DROP_BIT 0
`define DIG_STAT_MERR_BIT 1
`define DIG_STAT_OVAL_BIT 2
`define DIG_STAT_LAST_LSB 4
`define DIG_STAT_LAST_MSB 7

// ****************************************
// capture modes
// ****************************************
`define DIG_MODE_SDR      2'h0
`define DIG_MODE_DDR      2'h1
`define DIG_MODE_GEAR     2'h2

// ****************************************
// sizes
// ****************************************
`define DIG_DLY_TAPS      16
`define DIG_WORD_W        4

`endif

// *** src/dig_sync.v ***
// two flip-flop synchroniser with edge detection, one per bit
module dig_sync #(
    parameter W = 1
) (
    input  wire         sys_clk,
    input  wire         resetn,
    input  wire [W-1:0] d,
    output wire [W-1:0] q,
    output wire [W-1:0] rise,
    output wire [W-1:0] fall
);

    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;

    // ****************************************
    // per bit chain
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            // first stage feeds only the second
            always @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    s1_reg[i] <= 1'b0;
                    s2_reg[i] <= 1'b0;
                    s3_reg[i] <= 1'b0;
                end else begin
                    s1_reg[i] <= d[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                end
            end
            assign q[i]    = s2_reg[i];
            assign rise[i] = s2_reg[i] & ~s3_reg[i];
            assign fall[i] = ~s2_reg[i] & s3_reg[i];
        end
    endgenerate

endmodule // dig_sync

// *** src/dig_buf2.v ***
// two-entry buffer with valid and ready on both sides
module dig_buf2 #(
    parameter W = 4
) (
    input  wire         sys_clk,
    input  wire         resetn,
    input  wire [W-1:0] in_data,
    input  wire         in_valid,
    output wire         in_ready,
    output wire [W-1:0] out_data,
    output wire         out_valid,
    input  wire         out_ready
);

    reg [W-1:0] d0_reg;
    reg [W-1:0] d1_reg;
    reg         v0_reg;
    reg         v1_reg;
    wire        pop;
    wire        push;

    assign pop       = v0_reg & out_ready;
    assign push      = in_valid & ~v1_reg;
    assign in_ready  = ~v1_reg;
    assign out_data  = d0_reg;
    assign out_valid = v0_reg;

    // ****************************************
    // head and second entry
    // ****************************************
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            d0_reg <= {W{1'b0}};
            d1_reg <= {W{1'b0}};
            v0_reg <= 1'b0;
            v1_reg <= 1'b0;
        end else if (pop) begin
            if (v1_reg) begin
                d0_reg <= d1_reg;
                v1_reg <= 1'b0;
            end else if (push) begin
                d0_reg <= in_data;
            end else begin
                v0_reg <= 1'b0;
            end
        end else if (push) begin
            if (!v0_reg) begin
                d0_reg <= in_data;
                v0_reg <= 1'b1;
            end else begin
                d1_reg <= in_data;
                v1_reg <= 1'b1;
            end
        end
    end

endmodule // dig_buf2

// *** test/dig_cap_chk.sv ***
// checker on the capture block ports: bus handshake, buffer head, bypass
`include "dig_defs.vh"

module dig_cap_chk (
    input logic        sys_clk,
    input logic        resetn,
    input logic [3:0]  avs_address,
    input logic        avs_read,
    input logic        avs_write,
    input logic [31:0] avs_readdata,
    input logic        avs_waitrequest,
    input logic [3:0]  cap_data,
    input logic        cap_valid,
    input logic        cap_ready,
    input logic        pad_input,
    input logic        comb_input_bypass,
    input logic        clock_input_bypass
);
    timeunit 1ns;
    timeprecision 100ps;

    // ********
    // helpers
    // ********
    logic req;
    logic rd_seen;
    assign req = avs_read | avs_write;
    assign rd_seen = avs_read & avs_waitrequest;

    default clocking dcb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // ********
    // assertions
    // ********
    AST_WAIT_ANSWER: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest not low one cycle after request");
    AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_WAIT_IDLE: assert property (!req |-> avs_waitrequest)
        else $error("waitrequest low without request");
    AST_UNMAPPED_ZERO: assert property (rd_seen && avs_address != `DIG_CTRL_OFS
        && avs_address != `DIG_STAT_OFS |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_CTRL_SPARE: assert property (rd_seen && avs_address == `DIG_CTRL_OFS
        |=> avs_readdata[31:12] == 20'h0 && avs_readdata[7:5] == 3'h0)
        else $error("spare control bits not zero");
    AST_STAT_VALID: assert property (rd_seen && avs_address == `DIG_STAT_OFS
        |=> avs_readdata[2] == $past(cap_valid) && avs_readdata[31:8] == 24'h0)
        else $error("status valid bit wrong");
    // stalled head must not move
    AST_CAP_HOLD: assert property (cap_valid && !cap_ready |=> cap_valid && $stable(cap_data))
        else $error("buffer head changed while stalled");
    AST_CAP_DRAIN: assert property ($fell(cap_valid) |-> $past(cap_ready))
        else $error("valid dropped without acceptance");
    AST_BYPASS_PAIR: assert property (comb_input_bypass == clock_input_bypass)
        else $error("bypass outputs differ");
    // two sync stages plus the output register
    AST_BYPASS_LAG: assert property ($past(resetn, 3) |-> comb_input_bypass == $past(pad_input, 3))
        else $error("bypass does not follow the pad");

    cover property (req && !avs_waitrequest);
    cover property (cap_valid && !cap_ready ##1 cap_valid && cap_ready);
    cover property ($rose(comb_input_bypass));
endmodule // dig_cap_chk

bind dig_input_capture dig_cap_chk u_chk (.sys_clk, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .cap_data, .cap_valid, .cap_ready,
    .pad_input, .comb_input_bypass, .clock_input_bypass);

// *** test/dig_link_model.sv ***
// model of the transmitter and strobe read control on the far side
module dig_link_model (
    output logic pad_input,
    output logic strobe_read_clock,
    output logic edge_clock,
    output logic sync_clock_polarity,
    output logic sync_transfer_latch
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        pad_input = 1'b0;
        strobe_read_clock = 1'b0;
        edge_clock = 1'b0;
        sync_clock_polarity = 1'b0;
        sync_transfer_latch = 1'b0;
    end

    task ctl(input logic pol, input logic lat);
        sync_clock_polarity <= pol;
        sync_transfer_latch <= lat;
    endtask

    task set_pad(input logic v);
        pad_input <= v;
    endtask

    task frame(input logic [7:0] b, input int n, input logic strobe);
        #1.3;
        for (int i = 0; i < n; i++) begin
            pad_input = b[i];
            #8;
            if (strobe)
                strobe_read_clock = ~strobe_read_clock;
            else
                edge_clock = ~edge_clock;
            #8;
        end
        // released line shows no stale bit
        pad_input = ~pad_input;
    endtask
endmodule // dig_link_model

// *** test/testbench.sv ***
// self-checking bench of the ddr input capture and gearbox block
`include "dig_defs.vh"

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk, resetn, avs_read, avs_write, cap_ready, cap_valid, sdr_data;
    logic        avs_waitrequest, comb_input_bypass, clock_input_bypass;
    logic        pad_input, strobe_read_clock, edge_clock;
    logic        sync_clock_polarity, sync_transfer_latch;
    logic        gearbox_out_pos_first, gearbox_out_neg_first;
    logic        gearbox_out_pos_second, gearbox_out_neg_second;
    logic [3:0]  avs_address, dynamic_delay_sel, cap_data;
    logic [31:0] avs_writedata, avs_readdata, rdv;
    logic [3:0]  words[$];
    int          err_count, checks_done;

    dig_input_capture dut (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .pad_input, .strobe_read_clock,
        .edge_clock, .sync_clock_polarity, .sync_transfer_latch, .dynamic_delay_sel,
        .comb_input_bypass, .clock_input_bypass, .sdr_data, .cap_data, .cap_valid,
        .cap_ready, .gearbox_out_pos_first, .gearbox_out_neg_first,
        .gearbox_out_pos_second, .gearbox_out_neg_second);

    dig_link_model link (.pad_input, .strobe_read_clock, .edge_clock,
        .sync_clock_polarity, .sync_transfer_latch);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (cap_valid === 1'b1 && cap_ready === 1'b1)
            words.push_back(cap_data);
    end

    // ********
    // helpers
    // ********
    task close_out;
        $display("mismatches %0d, comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // hold the request until waitrequest is sampled low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 100)
            chk(32'h1, 32'h0);
        rdv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdv & m, exp);
    endtask

    task lat(output int n);
        n = 0;
        link.set_pad(~pad_input);
        @(posedge sys_clk);
        while (sdr_data !== pad_input && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
    endtask

    // ********
    // scenarios
    // ********
    task t_regs;
        rdc(`DIG_CTRL_OFS, 32'hffffffff, 32'h0);
        bus(1'b1, `DIG_CTRL_OFS, 32'hffffffff);
        rdc(`DIG_CTRL_OFS, 32'hffffffff, 32'hf1f);
        rdc(`DIG_STAT_OFS, 32'h2, 32'h2);
        bus(1'b1, 4'h8, 32'hffffffff);
        rdc(4'h8, 32'hffffffff, 32'h0);
        rdc(`DIG_CTRL_OFS, 32'hffffffff, 32'hf1f);
    endtask

    task t_sdr;
        bus(1'b1, `DIG_CTRL_OFS, 32'h0);
        link.set_pad(1'b1);
        cyc(8);
        chk(sdr_data, 1'b1);
        chk(comb_input_bypass, 1'b1);
        chk(clock_input_bypass, 1'b1);
        bus(1'b1, `DIG_CTRL_OFS, 32'h1);
        link.set_pad(1'b0);
        cyc(8);
        chk(sdr_data, 1'b1);
        chk(comb_input_bypass, 1'b0);
    endtask

    // latency difference isolates the tap count
    task t_delay;
        int l0, l1;
        bus(1'b1, `DIG_CTRL_OFS, 32'h008);
        cyc(24);
        lat(l0);
        bus(1'b1, `DIG_CTRL_OFS, 32'h908);
        cyc(24);
        lat(l1);
        chk(l1 - l0, 32'd9);
        dynamic_delay_sel <= 4'hf;
        bus(1'b1, `DIG_CTRL_OFS, 32'h018);
        cyc(24);
        lat(l1);
        chk(l1 - l0, 32'd15);
    endtask

    task t_ddr;
        bus(1'b1, `DIG_CTRL_OFS, 32'h001);
        words.delete();
        link.frame(8'h09, 4, 1'b0);
        cyc(20);
        chk(words.size(), 32'd2);
        chk(words[0], 4'h2);
        chk(words[1], 4'h1);
        link.ctl(1'b1, 1'b0);
        cyc(6);
        link.frame(8'h06, 4, 1'b0);
        cyc(20);
        chk(words[$], 4'h3);
        link.ctl(1'b0, 1'b0);
    endtask

    task t_mem;
        bus(1'b1, `DIG_CTRL_OFS, 32'h005);
        words.delete();
        link.frame(8'h01, 2, 1'b0);
        cyc(20);
        chk(words.size(), 32'd0);
        link.frame(8'h02, 2, 1'b1);
        cyc(20);
        chk(words.size(), 32'd1);
        chk(words[$], 4'h1);
    endtask

    task t_gear;
        bus(1'b1, `DIG_CTRL_OFS, 32'h002);
        words.delete();
        link.frame(8'h09, 4, 1'b0);
        cyc(20);
        chk(words.size(), 32'd0);
        link.ctl(1'b0, 1'b1);
        cyc(12);
        chk(words.size(), 32'd1);
        chk(words[$], 4'h6);
        chk({gearbox_out_pos_second, gearbox_out_neg_second, gearbox_out_pos_first,
             gearbox_out_neg_first}, 4'h6);
        link.ctl(1'b0, 1'b0);
    endtask

    // third word meets a full buffer
    task t_buf;
        bus(1'b1, `DIG_CTRL_OFS, 32'h001);
        cap_ready <= 1'b0;
        words.delete();
        link.frame(8'h1b, 6, 1'b0);
        cyc(20);
        chk(cap_data, 4'h3);
        rdc(`DIG_STAT_OFS, 32'h5, 32'h5);
        cap_ready <= 1'b1;
        cyc(6);
        chk(words.size(), 32'd2);
        chk(words[1], 4'h1);
        chk(cap_valid, 1'b0);
        bus(1'b1, `DIG_STAT_OFS, 32'h1);
        rdc(`DIG_STAT_OFS, 32'h7, 32'h0);
    endtask

    initial begin
        #100us;
        err_count++;
        close_out;
    end

    initial begin
        resetn = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        dynamic_delay_sel = 4'h0;
        cap_ready = 1'b1;
        err_count = 0;
        checks_done = 0;
        cyc(2);
        resetn <= 1'b1;
        cyc(1);
        t_regs;
        t_sdr;
        t_delay;
        t_ddr;
        t_mem;
        t_gear;
        t_buf;
        close_out;
    end
endmodule // testbench
